/* oc_sense_regs.sv */
// Overcurrent protection and sense-amplifier configuration registers with fault handling.
// Assumes the serial frame decoder delivers word writes and reads on the register port
// in this clock domain; comparator and PWM pins arrive asynchronously.
`timescale 1ns/100ps
// How it works
// - Retry wait bit picks 4 ms (0) or 50 us (1); default 0.
// - Dead time code picks 50, 100, 200 or 400 ns; default 01.
// - Response 00 latches the fault until an explicit clear.
// - Response 01, default, clears the fault after the retry wait.
// - Response 10 reports the fault but takes no protective action.
// - Response 11 neither reports nor acts.
// - Overcurrent must persist 2, 4, 6 or 8 us before acting; default 01.
// - Four-bit drain-source trip code; default 1001.
// - Writing amplifier source 1 also sets the low-side path bit.
// - Reference divide bit: 0 full reference, 1 half; default 1.
// - Low-side path bit picks negative or positive shunt pin; default 0.
// - Gain code picks 5, 10, 20 or 40 V/V; default 10.
// - Shunt fault disable bit 1 ignores shunt overcurrent; default 0.
// - Three trim bits short each amplifier input for offset calibration.
// - Shunt trip code picks 0.25, 0.5, 0.75 or 1 V; default 11.
// - Sense control register exists only on amplifier variants.
// - Per-cycle bit clears retry faults on a new PWM input.
module oc_sense_regs #(
   parameter int RETRY_LONG = oc_sense_pkg::RETRY_LONG_US, // Long retry wait in microseconds.
   parameter bit HAS_SENSE_AMP = 1'b1 // Variant carries the sense amplifiers.
) (
   input wire logic ref_clk, // 50 MHz clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [3:0] reg_addr, // Register address.
   input wire logic [10:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [10:0] reg_rdata, // Read data.
   output logic reg_rdata_valid, // Read data valid pulse.
   input wire logic ds_trip_pin, // Drain-source comparator, asynchronous.
   input wire logic shunt_trip_pin, // Shunt comparator, asynchronous.
   input wire logic pwm_in_pin, // PWM input, asynchronous.
   input wire logic per_cycle_fault_clear, // Per-cycle clear bit from gate-drive settings.
   input wire logic clear_faults, // Explicit fault clear pulse.
   output logic [4:0] dead_time_cycles, // Dead time in clock cycles.
   output logic [3:0] drain_source_trip_sel, // Drain-source threshold code.
   output logic amp_input_source_sel, // Amplifier positive input is the switch node.
   output logic amp_ref_half_sel, // Amplifier reference halved.
   output logic lowside_measure_path_sel, // Low-side measurement to negative shunt pin.
   output logic [1:0] amp_gain_sel, // Amplifier gain code.
   output logic amp_a_offset_trim, // Short amplifier A inputs.
   output logic amp_b_offset_trim, // Short amplifier B inputs.
   output logic amp_c_offset_trim, // Short amplifier C inputs.
   output logic [1:0] shunt_trip_level_sel, // Shunt threshold code.
   output logic drain_source_overcurrent, // Drain-source fault reported.
   output logic shunt_overcurrent, // Shunt fault reported.
   output logic gate_shutdown // Outputs forced off by a fault.
);
   import oc_sense_pkg::*;

   logic [10:0] overcurrent_ctrl;
   logic [10:0] sense_ctrl;
   logic [5:0] tick_cnt;
   logic tick_us;
   logic [1:0] ds_sync;
   logic [1:0] shunt_sync;
   logic [1:0] pwm_sync;
   logic pwm_last;
   logic pwm_edge;
   logic [3:0] filter_ticks;
   logic [15:0] retry_ticks;
   logic ds_shutdown;
   logic shunt_shutdown;
   response_e response;
   logic [10:0] sense_wdata;
   // Longest a short-wait retry fault may stand: 50 ticks of 50 cycles plus tick phase and pipeline slack.
   localparam int RETRY_HOLD_MAX = 2600;
   logic [11:0] retry_hold_cnt;

   assign response = response_e'(overcurrent_ctrl[RESPONSE_LSB +: 2]);

   // Register writes. The switch-node source forces the low-side path on.
   always_comb begin
      sense_wdata = reg_wdata;
      if (reg_wdata[AMP_SRC_BIT]) begin
         sense_wdata[LS_PATH_BIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         overcurrent_ctrl <= OVERCURRENT_CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_OVERCURRENT_CTRL) begin
         overcurrent_ctrl <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sense_ctrl <= SENSE_CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_SENSE_CTRL && HAS_SENSE_AMP) begin
         sense_ctrl <= sense_wdata;
      end
   end

   // Reads answer one cycle after the strobe; absent registers read as zero.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 11'h000;
         reg_rdata_valid <= 1'b0;
      end else begin
         reg_rdata_valid <= reg_rd;
         if (!reg_rd) begin
            reg_rdata <= 11'h000;
         end else if (reg_addr == ADDR_OVERCURRENT_CTRL) begin
            reg_rdata <= overcurrent_ctrl;
         end else if (reg_addr == ADDR_SENSE_CTRL && HAS_SENSE_AMP) begin
            reg_rdata <= sense_ctrl;
         end else begin
            reg_rdata <= 11'h000;
         end
      end
   end

   // Field outputs come straight from the register flops.
   assign drain_source_trip_sel = overcurrent_ctrl[DS_TRIP_LSB +: 4];
   assign amp_input_source_sel = sense_ctrl[AMP_SRC_BIT];
   assign amp_ref_half_sel = sense_ctrl[REF_HALF_BIT];
   assign lowside_measure_path_sel = sense_ctrl[LS_PATH_BIT];
   assign amp_gain_sel = sense_ctrl[GAIN_LSB +: 2];
   assign amp_a_offset_trim = sense_ctrl[TRIM_A_BIT];
   assign amp_b_offset_trim = sense_ctrl[TRIM_B_BIT];
   assign amp_c_offset_trim = sense_ctrl[TRIM_C_BIT];
   assign shunt_trip_level_sel = sense_ctrl[SHUNT_LVL_LSB +: 2];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dead_time_cycles <= DEAD_CYC_1;
      end else begin
         case (overcurrent_ctrl[DEAD_SEL_LSB +: 2])
            2'b00: dead_time_cycles <= DEAD_CYC_0;
            2'b01: dead_time_cycles <= DEAD_CYC_1;
            2'b10: dead_time_cycles <= DEAD_CYC_2;
            default: dead_time_cycles <= DEAD_CYC_3;
         endcase
      end
   end

   // Microsecond time base for deglitch and retry counting.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || tick_cnt == TICK_LAST) begin
         tick_cnt <= 6'h00;
      end else begin
         tick_cnt <= tick_cnt + 6'h01;
      end
   end

   assign tick_us = tick_cnt == TICK_LAST;

   // Pins are synchronised before any logic looks at them.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ds_sync <= 2'b00;
         shunt_sync <= 2'b00;
         pwm_sync <= 2'b00;
         pwm_last <= 1'b0;
      end else begin
         ds_sync <= {ds_sync[0], ds_trip_pin};
         shunt_sync <= {shunt_sync[0], shunt_trip_pin};
         pwm_sync <= {pwm_sync[0], pwm_in_pin};
         pwm_last <= pwm_sync[1];
      end
   end

   assign pwm_edge = pwm_sync[1] && !pwm_last;
   assign filter_ticks = 4'((32'(overcurrent_ctrl[FILTER_SEL_LSB +: 2]) + 32'd1) * FILTER_STEP_US);
   assign retry_ticks = overcurrent_ctrl[RETRY_SEL_BIT] ? 16'(RETRY_SHORT_US) : 16'(RETRY_LONG);

   oc_fault_channel ds_channel (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .tick_us(tick_us),
      .trip(ds_sync[1]),
      .enable(1'b1),
      .response(response),
      .filter_ticks(filter_ticks),
      .retry_ticks(retry_ticks),
      .per_cycle_clear(per_cycle_fault_clear),
      .pwm_edge(pwm_edge),
      .clear_fault(clear_faults),
      .fault_flag(drain_source_overcurrent),
      .shutdown(ds_shutdown)
   );

   oc_fault_channel shunt_channel (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .tick_us(tick_us),
      .trip(shunt_sync[1]),
      .enable(HAS_SENSE_AMP && !sense_ctrl[SHUNT_DIS_BIT]),
      .response(response),
      .filter_ticks(filter_ticks),
      .retry_ticks(retry_ticks),
      .per_cycle_clear(per_cycle_fault_clear),
      .pwm_edge(pwm_edge),
      .clear_fault(clear_faults),
      .fault_flag(shunt_overcurrent),
      .shutdown(shunt_shutdown)
   );

   // One cycle later than the channel flags, so a fault never races its own report.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gate_shutdown <= 1'b0;
      end else begin
         gate_shutdown <= ds_shutdown || shunt_shutdown;
      end
   end

   // Counts how long a short-wait drain-source retry fault has stood; saturates so it never wraps back to legal.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !drain_source_overcurrent || response != RESP_RETRY || !overcurrent_ctrl[RETRY_SEL_BIT]) begin
         retry_hold_cnt <= 12'h000;
      end else if (retry_hold_cnt != 12'hFFF) begin
         retry_hold_cnt <= retry_hold_cnt + 12'h001;
      end
   end

   a_reset_defaults: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> overcurrent_ctrl == OVERCURRENT_CTRL_RESET && sense_ctrl == SENSE_CTRL_RESET)
      else $error("Registers not at defaults after reset.");

   a_read_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_OVERCURRENT_CTRL |=> reg_rdata_valid && reg_rdata == $past(overcurrent_ctrl))
      else $error("Read data does not match the register.");

   a_source_sets_path: assert property (@(posedge ref_clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_SENSE_CTRL && reg_wdata[AMP_SRC_BIT] && HAS_SENSE_AMP
      |=> lowside_measure_path_sel && amp_input_source_sel)
      else $error("Switch-node source did not force the low-side path.");

   a_dead_time_max: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (overcurrent_ctrl[DEAD_SEL_LSB +: 2] == 2'b11) [*2] |-> dead_time_cycles == 5'd20)
      else $error("Longest dead time is not 20 cycles.");

   a_latch_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
      drain_source_overcurrent && response == RESP_LATCH && !clear_faults && $stable(response)
      |=> drain_source_overcurrent)
      else $error("Latched fault dropped without a clear.");

   a_off_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (response == RESP_OFF) [*3] |-> !drain_source_overcurrent && !shunt_overcurrent && !gate_shutdown)
      else $error("Fault reported while responses are off.");

   a_report_passive: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (response == RESP_REPORT) [*3] |-> !gate_shutdown)
      else $error("Report-only mode took protective action.");

   a_shunt_disabled: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sense_ctrl[SHUNT_DIS_BIT]) [*3] |-> !shunt_overcurrent)
      else $error("Shunt fault reported while disabled.");

   a_deglitch_min: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(drain_source_overcurrent) |-> $past(ds_sync[1], 60))
      else $error("Fault acted before the deglitch time.");

   a_retry_short: assert property (@(posedge ref_clk) disable iff (sys_rst)
      32'(retry_hold_cnt) <= RETRY_HOLD_MAX)
      else $error("Retry fault did not clear after the short wait.");

   a_per_cycle_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      drain_source_overcurrent && ds_shutdown && response == RESP_RETRY && per_cycle_fault_clear && pwm_edge
      |=> !drain_source_overcurrent)
      else $error("New PWM input did not clear the retry fault.");

   c_latched_fault: cover property (@(posedge ref_clk) disable iff (sys_rst)
      drain_source_overcurrent && response == RESP_LATCH);
   c_retry_fault: cover property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(drain_source_overcurrent) && response == RESP_RETRY);
   c_pwm_clear: cover property (@(posedge ref_clk) disable iff (sys_rst)
      ds_shutdown && per_cycle_fault_clear && pwm_edge);
   c_shunt_fault: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(shunt_overcurrent));

endmodule : oc_sense_regs

/* oc_sense_pkg.sv */
// Constants shared by the overcurrent and sense-amplifier configuration block.
// Assumes a single 50 MHz clock domain; dead times are converted to cycles here, other times count microsecond ticks.
package oc_sense_pkg;

   // Clock and time base.
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int CLK_MHZ = CLK_FREQ_HZ / 1_000_000;
   localparam int NS_PER_US = 1000;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

   // Register map.
   localparam int REG_W = 11;
   localparam logic [3:0] ADDR_OVERCURRENT_CTRL = 4'h5;
   localparam logic [3:0] ADDR_SENSE_CTRL = 4'h6;
   localparam logic [10:0] OVERCURRENT_CTRL_RESET = 11'h159;
   localparam logic [10:0] SENSE_CTRL_RESET = 11'h283;

   // Overcurrent control field positions.
   localparam int RETRY_SEL_BIT = 10;
   localparam int DEAD_SEL_LSB = 8;
   localparam int RESPONSE_LSB = 6;
   localparam int FILTER_SEL_LSB = 4;
   localparam int DS_TRIP_LSB = 0;

   // Sense control field positions.
   localparam int AMP_SRC_BIT = 10;
   localparam int REF_HALF_BIT = 9;
   localparam int LS_PATH_BIT = 8;
   localparam int GAIN_LSB = 6;
   localparam int SHUNT_DIS_BIT = 5;
   localparam int TRIM_A_BIT = 4;
   localparam int TRIM_B_BIT = 3;
   localparam int TRIM_C_BIT = 2;
   localparam int SHUNT_LVL_LSB = 0;

   // Retry waits, in microseconds.
   localparam int RETRY_SHORT_US = 50;
   localparam int RETRY_LONG_US = 4000;

   // Dead times in ns; a least time, so cycle counts round up.
   localparam int DEAD_NS_0 = 50;
   localparam int DEAD_NS_1 = 100;
   localparam int DEAD_NS_2 = 200;
   localparam int DEAD_NS_3 = 400;
   localparam logic [4:0] DEAD_CYC_0 = 5'((DEAD_NS_0 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam logic [4:0] DEAD_CYC_1 = 5'((DEAD_NS_1 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam logic [4:0] DEAD_CYC_2 = 5'((DEAD_NS_2 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam logic [4:0] DEAD_CYC_3 = 5'((DEAD_NS_3 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);

   // Deglitch step: code n selects (n + 1) * 2 us.
   localparam int FILTER_STEP_US = 2;

   typedef enum logic [1:0] {
      RESP_LATCH  = 2'b00,
      RESP_RETRY  = 2'b01,
      RESP_REPORT = 2'b10,
      RESP_OFF    = 2'b11
   } response_e;

   typedef enum logic [1:0] {
      CH_IDLE     = 2'b00,
      CH_LATCHED  = 2'b01,
      CH_RETRYING = 2'b10,
      CH_REPORTED = 2'b11
   } channel_state_e;

endpackage : oc_sense_pkg

/* oc_fault_channel.sv */
// One overcurrent fault channel: deglitch filter plus response state machine.
// Assumes trip is already synchronised and tick_us is a one-cycle pulse each microsecond.
`timescale 1ns/100ps
module oc_fault_channel (
   input wire logic ref_clk, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic tick_us, // One-cycle pulse every microsecond.
   input wire logic trip, // Synchronised comparator level.
   input wire logic enable, // Channel may detect faults.
   input wire oc_sense_pkg::response_e response, // Selected response mode.
   input wire logic [3:0] filter_ticks, // Deglitch time in microseconds.
   input wire logic [15:0] retry_ticks, // Retry wait in microseconds.
   input wire logic per_cycle_clear, // Clear retry faults on new PWM input.
   input wire logic pwm_edge, // One-cycle pulse on a new PWM input.
   input wire logic clear_fault, // Explicit fault clear pulse.
   output logic fault_flag, // Fault reported.
   output logic shutdown // Protective action requested.
);
   import oc_sense_pkg::*;

   logic [3:0] filt_cnt;
   logic [15:0] retry_cnt;
   logic qualified;
   channel_state_e state;
   channel_state_e next_state;

   // The condition must persist for the whole deglitch time before it counts.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !trip) begin
         filt_cnt <= 4'h0;
      end else if (tick_us && filt_cnt < filter_ticks) begin
         filt_cnt <= filt_cnt + 4'h1;
      end
   end

   assign qualified = trip && enable && response != RESP_OFF && filt_cnt >= filter_ticks;

   always_comb begin
      next_state = state;
      case (state)
         CH_IDLE: begin
            if (qualified) begin
               case (response)
                  RESP_LATCH: next_state = CH_LATCHED;
                  RESP_RETRY: next_state = CH_RETRYING;
                  default: next_state = CH_REPORTED;
               endcase
            end
         end
         CH_LATCHED: begin
            // A clear arriving with a live event leaves the fault set.
            if (clear_fault && !qualified) begin
               next_state = CH_IDLE;
            end
         end
         CH_RETRYING: begin
            if (retry_cnt >= retry_ticks || (per_cycle_clear && pwm_edge)) begin
               next_state = CH_IDLE;
            end
         end
         CH_REPORTED: begin
            if (clear_fault && !qualified) begin
               next_state = CH_IDLE;
            end
         end
         default: next_state = CH_IDLE;
      endcase
      if (response == RESP_OFF || !enable) begin
         next_state = CH_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= CH_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || state != CH_RETRYING) begin
         retry_cnt <= 16'h0000;
      end else if (tick_us) begin
         retry_cnt <= retry_cnt + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fault_flag <= 1'b0;
         shutdown <= 1'b0;
      end else begin
         fault_flag <= next_state != CH_IDLE;
         shutdown <= next_state == CH_LATCHED || next_state == CH_RETRYING;
      end
   end

endmodule : oc_fault_channel

/* reg_host.sv */
// Register host model: issues word writes and reads on the parallel register port.
// Assumes requests launch on a falling edge and are taken on the following rising edge.
`timescale 1ns/100ps
module reg_host (
   input wire logic ref_clk, // System clock.
   output logic [3:0] reg_addr, // Register address.
   output logic [10:0] reg_wdata, // Write data.
   output logic reg_wr, // Write strobe.
   output logic reg_rd, // Read strobe.
   input wire logic [10:0] reg_rdata, // Read data.
   input wire logic reg_rdata_valid // Read data valid.
);
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 11'h000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Address and data go to the inverse of the last value when idle, so stale values never look held.
   task automatic access(input logic wr, input logic [3:0] a, input logic [10:0] d, output logic [10:0] q,
                         output logic v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = !wr;
      @(negedge ref_clk);
      q = reg_rdata;
      v = reg_rdata_valid;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : access
endmodule : reg_host

/* testbench.sv */
// Self-checking bench for the overcurrent and sense configuration registers.
// Assumes the register host model on the word port; comparators and PWM are driven here.
`timescale 1ns/100ps
module testbench;
   import oc_sense_pkg::*;
   typedef struct {logic [3:0] a; logic [10:0] d; logic [10:0] q; logic [4:0] dt;} row_s;
   localparam int RETRY_US = 20;
   logic ref_clk, sys_rst, reg_wr, reg_rd, reg_rdata_valid, v;
   logic ds_trip_pin, shunt_trip_pin, pwm_in_pin, per_cycle_fault_clear, clear_faults;
   logic [3:0] reg_addr, drain_source_trip_sel;
   logic [10:0] reg_wdata, reg_rdata, q;
   logic [4:0] dead_time_cycles;
   logic amp_input_source_sel, amp_ref_half_sel, lowside_measure_path_sel;
   logic amp_a_offset_trim, amp_b_offset_trim, amp_c_offset_trim;
   logic [1:0] amp_gain_sel, shunt_trip_level_sel;
   logic drain_source_overcurrent, shunt_overcurrent, gate_shutdown;
   logic [9:0] sense_fields;
   int n_mismatch = 0;
   int n_compared = 0;
   row_s rows [8] = '{
      '{4'h5, 11'h000, 11'h000, DEAD_CYC_0}, '{4'h5, 11'h100, 11'h100, DEAD_CYC_1},
      '{4'h5, 11'h200, 11'h200, DEAD_CYC_2}, '{4'h5, 11'h7FF, 11'h7FF, DEAD_CYC_3},
      '{4'h6, 11'h400, 11'h500, DEAD_CYC_3}, '{4'h6, 11'h2AA, 11'h2AA, DEAD_CYC_3},
      '{4'h6, 11'h155, 11'h155, DEAD_CYC_3}, '{4'h3, 11'h7FF, 11'h000, DEAD_CYC_3}};

   assign sense_fields = {amp_input_source_sel, amp_ref_half_sel, lowside_measure_path_sel, amp_gain_sel,
                          amp_a_offset_trim, amp_b_offset_trim, amp_c_offset_trim, shunt_trip_level_sel};

   oc_sense_regs #(.RETRY_LONG(RETRY_US), .HAS_SENSE_AMP(1'b1)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
      .ds_trip_pin(ds_trip_pin), .shunt_trip_pin(shunt_trip_pin), .pwm_in_pin(pwm_in_pin),
      .per_cycle_fault_clear(per_cycle_fault_clear), .clear_faults(clear_faults),
      .dead_time_cycles(dead_time_cycles), .drain_source_trip_sel(drain_source_trip_sel),
      .amp_input_source_sel(amp_input_source_sel), .amp_ref_half_sel(amp_ref_half_sel),
      .lowside_measure_path_sel(lowside_measure_path_sel), .amp_gain_sel(amp_gain_sel),
      .amp_a_offset_trim(amp_a_offset_trim), .amp_b_offset_trim(amp_b_offset_trim),
      .amp_c_offset_trim(amp_c_offset_trim), .shunt_trip_level_sel(shunt_trip_level_sel),
      .drain_source_overcurrent(drain_source_overcurrent), .shunt_overcurrent(shunt_overcurrent),
      .gate_shutdown(gate_shutdown));

   reg_host host (
      .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic summarize;
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic reset_check;
      @(negedge ref_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      chk("dead time", DEAD_CYC_1, dead_time_cycles);
      chk("faults", 3'b000, {drain_source_overcurrent, shunt_overcurrent, gate_shutdown});
      host.access(1'b0, 4'h5, 11'h000, q, v);
      chk("overcurrent reg", 11'h159, q);
      host.access(1'b0, 4'h6, 11'h000, q, v);
      chk("sense reg", 11'h283, q);
      $display("Test reset done");
   endtask : reset_check

   // Tick phase is unknown to the bench, so latency and hold are judged within a window.
   task automatic trip_test(input logic sh, input logic [10:0] cfg, input int lat, input logic ef,
                            input logic es, input int hold);
      int n;
      logic f;
      host.access(1'b1, 4'h5, cfg, q, v);
      ds_trip_pin = !sh;
      shunt_trip_pin = sh;
      n = 0;
      f = 1'b0;
      while (f !== 1'b1 && n < 600) begin
         @(negedge ref_clk);
         n++;
         f = sh ? shunt_overcurrent : drain_source_overcurrent;
      end
      chk("fault flag", ef, f);
      if (ef) begin
         chk("filter time", 1'b1, n >= lat * 50 - 50 && n <= lat * 50 + 10);
         @(negedge ref_clk);
         chk("shutdown", es, gate_shutdown);
      end
      ds_trip_pin = 1'b0;
      shunt_trip_pin = 1'b0;
      pwm_in_pin = per_cycle_fault_clear;
      n = 0;
      while (f === 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
         f = sh ? shunt_overcurrent : drain_source_overcurrent;
      end
      if (hold > 0) chk("hold time", 1'b1, n >= hold * 50 - 80 && n <= hold * 50 + 80);
      else if (ef) chk("held", 3000, n);
      clear_faults = 1'b1;
      @(negedge ref_clk);
      clear_faults = 1'b0;
      pwm_in_pin = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("cleared", 3'b000, {drain_source_overcurrent, shunt_overcurrent, gate_shutdown});
      $display("Test trip %h done", cfg);
   endtask : trip_test

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      #1_000_000;
      n_mismatch++;
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      {ds_trip_pin, shunt_trip_pin, pwm_in_pin, per_cycle_fault_clear, clear_faults} = 5'h00;
      repeat (8) @(negedge ref_clk);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         host.access(1'b1, rows[i].a, rows[i].d, q, v);
         host.access(1'b0, rows[i].a, 11'h000, q, v);
         chk("read valid", 1'b1, v);
         chk("readback", rows[i].q, q);
         chk("dead time", rows[i].dt, dead_time_cycles);
         if (rows[i].a == 4'h5) chk("ds level", rows[i].q[3:0], drain_source_trip_sel);
         if (rows[i].a == 4'h6) chk("sense", {rows[i].q[10:6], rows[i].q[4:0]}, sense_fields);
         $display("Test row %0d done", i);
      end
      reset_check();
      for (int d = 0; d < 4; d++) trip_test(1'b0, 11'h549 + 11'(d * 16), 2 * (d + 1), 1'b1, 1'b1, 50);
      trip_test(1'b0, 11'h149, 2, 1'b1, 1'b1, RETRY_US);
      trip_test(1'b0, 11'h109, 2, 1'b1, 1'b1, 0);
      trip_test(1'b0, 11'h189, 2, 1'b1, 1'b0, 0);
      trip_test(1'b0, 11'h1C9, 2, 1'b0, 1'b0, 0);
      per_cycle_fault_clear = 1'b1;
      trip_test(1'b0, 11'h149, 2, 1'b1, 1'b1, 1);
      per_cycle_fault_clear = 1'b0;
      host.access(1'b1, 4'h6, 11'h283, q, v);
      trip_test(1'b1, 11'h549, 2, 1'b1, 1'b1, 50);
      host.access(1'b1, 4'h6, 11'h2A3, q, v);
      trip_test(1'b1, 11'h549, 2, 1'b0, 1'b0, 0);
      summarize();
   end
endmodule : testbench
